/* File: inc/mlr_pkg.sv */
// What this block does
// - Internal loopback when not disabled since reset and select a high, b low; reset enters it.
// - Internal loopback shows status bits 5 and 7 high, bit 6 low.
// - Internal loopback drives transmit disable low, so both line drives high.
// - Internal loopback turns the precoder off; duobinary_off bit reads low.
// - Internal loopback disables silence adder while mgmt_request_n is low.
// - Internal loopback feeds rx_clock to the symbol-clock synchronizer, kept enabled.
// - Internal loopback disables no-transition detector; start delimiter ignores carrier; gain hold still follows.
// - External loopback when not disabled since reset and select a low, b high.
// - External loopback asserts its pin and shows status bits 6 and 7 high, bit 5 low.
// - External loopback: lost carrier does not disable transmitter or force line drives.
// - Equal select bits behave as loopback disabled.
// - Five 8-bit registers, status read-only, bit 0 least significant.
// - Status bits 0-2 capture jabber, fault and bad-input history at reset command.
// - Status bit 3 is inverted carrier detect; bit 4 shows transmitter disabled by reset.
// - Status bits 5,6 show current loopback; bit 7 shows loopback armed by reset.
// - Control bit 0 reads zero; bits 3 to 7 disable codec functions.
// - Output-control bits 0 to 2 disable precoder, bad-input detector, synchronizer.
// - Output-control bits 3 to 7 drive user outputs; reads return pin levels.
// - General I/O reads pin levels; written values drive once pin turns output.
// - Reset clears direction and general I/O registers.
// - Reset sets output-control bits 6,7 and clears bits 5 to 0.
// - Reset sets control bits 5,1, clears others; status bits 7,5,4 set, 6 clear.
// - Direction bit low makes pin input, high makes it output.
// - Write to status register acts as a read and changes nothing.
// - Loopback-disable history cleared on reset, set on loopback-disable command.
package mlr_pkg;
    localparam logic [5:0] ADDR_STATUS = 6'h00;
    localparam logic [5:0] ADDR_CONTROL = 6'h01;
    localparam logic [5:0] ADDR_OUTCTL = 6'h3d;
    localparam logic [5:0] ADDR_GPIO = 6'h3e;
    localparam logic [5:0] ADDR_DIR = 6'h3f;
    localparam logic [7:0] CONTROL_RESET = 8'h22;
    localparam logic [7:0] OUTCTL_RESET = 8'hc0;
    localparam logic [7:0] GPIO_RESET = 8'h00;
    localparam logic [7:0] DIR_RESET = 8'h00;
    localparam int SEL_A_BIT = 1;
    localparam int SEL_B_BIT = 2;
    localparam int SCRAMBLER_OFF_BIT = 3;
    localparam int DESCRAMBLER_OFF_BIT = 4;
    localparam int ADDER_OFF_BIT = 5;
    localparam int SUBTRACTER_OFF_BIT = 6;
    localparam int CORRECTOR_OFF_BIT = 7;
    localparam int DUOBINARY_OFF_BIT = 0;
    localparam int BAD_INPUT_OFF_BIT = 1;
    localparam int SYNC_OFF_BIT = 2;
    localparam int USER_OUT_LSB = 3;
    localparam int SYNC_STAGES = 2;
    typedef enum logic [2:0] {
        MLR_LOOP_NONE = 3'b001,
        MLR_LOOP_INT = 3'b010,
        MLR_LOOP_EXT = 3'b100
    } mlr_loop_type;
endpackage : mlr_pkg

/* File: hdl/mlr_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module mlr_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    // Data
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            meta_reg <= '0;
            sync_o <= '0;
        end else begin
            meta_reg <= async_i;
            sync_o <= meta_reg;
        end
    end
endmodule : mlr_sync
`default_nettype wire

/* File: hdl/mlr_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module mlr_regs (
    // Receive-side clock and pin reset
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    // Commands decoded from the management channel (one-cycle pulses)
    input wire logic reset_cmd_i,
    input wire logic loop_disable_cmd_i,
    input wire logic tx_enable_cmd_i,
    // Register access from the management octet engine
    input wire logic acc_valid_i,
    input wire logic acc_write_i,
    input wire logic [5:0] acc_addr_i,
    input wire logic [7:0] acc_wdata_i,
    output logic [7:0] acc_rdata_o,
    output logic acc_ack_o,
    // Asynchronous pins
    input wire logic jabber_n_i,
    input wire logic fault_n_i,
    input wire logic carrier_detect_i,
    input wire logic mgmt_request_n_i,
    input wire logic [4:0] user_out_level_i,
    input wire logic [7:0] gpio_pin_i,
    // Same-clock inputs from the codec
    input wire logic bad_input_i,
    input wire logic tx_error_off_i,
    input wire logic line_symbol_clock_i,
    input wire logic rx_clock_i,
    input wire logic raw_delim_found_i,
    // Loopback and pin outputs
    output logic int_loop_active_o,
    output logic ext_loop_active_o,
    output logic tx_disable_n_o,
    output logic line_drive_a_o,
    output logic line_drive_b_o,
    output logic [4:0] user_output_o,
    output logic [7:0] gpio_pin_o,
    output logic [7:0] gpio_pin_oe_o,
    // Codec controls
    output logic scrambler_off_o,
    output logic descrambler_off_o,
    output logic silence_adder_off_o,
    output logic silence_subtracter_off_o,
    output logic error_corrector_off_o,
    output logic duobinary_off_o,
    output logic bad_input_detect_off_o,
    output logic sync_disable_o,
    output logic sync_clock_sel_o,
    output logic no_transition_off_o,
    output logic start_delim_found_o,
    output logic gain_hold_n_o
);
    logic [7:0] control_reg;
    logic [7:0] outctl_reg;
    logic [7:0] gpio_reg;
    logic [7:0] dir_reg;
    logic [2:0] hist_reg;
    logic tx_off_reg;
    logic loop_disabled_reg;
    logic jabber_seen_reg;
    logic fault_seen_reg;
    logic bad_seen_reg;
    logic [7:0] status_flags;
    logic [16:0] pins_s;
    logic jabber_n_s;
    logic fault_n_s;
    logic carrier_s;
    logic mreq_n_s;
    logic [4:0] uout_s;
    logic [7:0] gpio_s;
    logic sel_a;
    logic sel_b;
    mlr_pkg::mlr_loop_type loop_mode;
    logic int_loop;
    logic ext_loop;
    logic loop_armed;
    logic tx_off_now;

    // Every pin passes two flops; low-active pins enter inverted so reset reads idle
    mlr_sync #(
        .WIDTH(17)
    ) u_pin_sync (
        .core_clk_i(core_clk_i),
        .reset_n_i(reset_n_i),
        .async_i({gpio_pin_i, user_out_level_i, ~mgmt_request_n_i, carrier_detect_i, ~fault_n_i, ~jabber_n_i}),
        .sync_o(pins_s)
    );
    assign jabber_n_s = ~pins_s[0];
    assign fault_n_s = ~pins_s[1];
    assign carrier_s = pins_s[2];
    assign mreq_n_s = ~pins_s[3];
    assign uout_s = pins_s[8:4];
    assign gpio_s = pins_s[16:9];

    function automatic logic addr_known(input logic [5:0] a);
        addr_known = (a == mlr_pkg::ADDR_STATUS) || (a == mlr_pkg::ADDR_CONTROL) ||
                     (a == mlr_pkg::ADDR_OUTCTL) || (a == mlr_pkg::ADDR_GPIO) ||
                     (a == mlr_pkg::ADDR_DIR);
    endfunction : addr_known

    function automatic logic wr_hit(input logic [5:0] want, input logic v, input logic w,
                                    input logic [5:0] a);
        wr_hit = v && w && (a == want);
    endfunction : wr_hit

    // Loopback mode decode
    assign sel_a = control_reg[mlr_pkg::SEL_A_BIT];
    assign sel_b = control_reg[mlr_pkg::SEL_B_BIT];
    always_comb begin
        if (loop_disabled_reg || (sel_a == sel_b)) begin
            loop_mode = mlr_pkg::MLR_LOOP_NONE;
        end else if (sel_a) begin
            loop_mode = mlr_pkg::MLR_LOOP_INT;
        end else begin
            loop_mode = mlr_pkg::MLR_LOOP_EXT;
        end
    end
    assign int_loop = (loop_mode == mlr_pkg::MLR_LOOP_INT);
    assign ext_loop = (loop_mode == mlr_pkg::MLR_LOOP_EXT);
    assign loop_armed = !loop_disabled_reg;

    // Loopback-disable history
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            loop_disabled_reg <= 1'b0;
        end else if (reset_cmd_i) begin
            loop_disabled_reg <= 1'b0;
        end else if (loop_disable_cmd_i) begin
            loop_disabled_reg <= 1'b1;
        end
    end

    // Transmitter disabled by reset until enable command
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tx_off_reg <= 1'b1;
        end else if (reset_cmd_i) begin
            tx_off_reg <= 1'b1;
        end else if (tx_enable_cmd_i) begin
            tx_off_reg <= 1'b0;
        end
    end

    // Error sources seen since last reset command
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            jabber_seen_reg <= 1'b0;
            fault_seen_reg <= 1'b0;
            bad_seen_reg <= 1'b0;
        end else if (reset_cmd_i) begin
            jabber_seen_reg <= 1'b0;
            fault_seen_reg <= 1'b0;
            bad_seen_reg <= 1'b0;
        end else begin
            jabber_seen_reg <= jabber_seen_reg | !jabber_n_s;
            fault_seen_reg <= fault_seen_reg | !fault_n_s;
            bad_seen_reg <= bad_seen_reg | (bad_input_i & !outctl_reg[mlr_pkg::BAD_INPUT_OFF_BIT]);
        end
    end

    // History latched only by reset command; the pin reset clears it
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            hist_reg <= 3'h0;
        end else if (reset_cmd_i) begin
            hist_reg[0] <= jabber_seen_reg | !jabber_n_s;
            hist_reg[1] <= fault_seen_reg | !fault_n_s;
            hist_reg[2] <= (bad_seen_reg | bad_input_i) & !outctl_reg[mlr_pkg::BAD_INPUT_OFF_BIT];
        end
    end

    // Control register, bit 0 never stored
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            control_reg <= mlr_pkg::CONTROL_RESET;
        end else if (reset_cmd_i) begin
            control_reg <= mlr_pkg::CONTROL_RESET;
        end else if (wr_hit(mlr_pkg::ADDR_CONTROL, acc_valid_i, acc_write_i, acc_addr_i)) begin
            control_reg <= {acc_wdata_i[7:1], 1'b0};
        end
    end

    // Output-control register
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            outctl_reg <= mlr_pkg::OUTCTL_RESET;
        end else if (reset_cmd_i) begin
            outctl_reg <= mlr_pkg::OUTCTL_RESET;
        end else if (wr_hit(mlr_pkg::ADDR_OUTCTL, acc_valid_i, acc_write_i, acc_addr_i)) begin
            outctl_reg <= acc_wdata_i;
        end
    end

    // General I/O value and direction registers
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            gpio_reg <= mlr_pkg::GPIO_RESET;
        end else if (reset_cmd_i) begin
            gpio_reg <= mlr_pkg::GPIO_RESET;
        end else if (wr_hit(mlr_pkg::ADDR_GPIO, acc_valid_i, acc_write_i, acc_addr_i)) begin
            gpio_reg <= acc_wdata_i;
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            dir_reg <= mlr_pkg::DIR_RESET;
        end else if (reset_cmd_i) begin
            dir_reg <= mlr_pkg::DIR_RESET;
        end else if (wr_hit(mlr_pkg::ADDR_DIR, acc_valid_i, acc_write_i, acc_addr_i)) begin
            dir_reg <= acc_wdata_i;
        end
    end

    // Status register assembled from live state
    assign status_flags = {loop_armed, ext_loop, int_loop, tx_off_reg, !carrier_s, hist_reg};

    // Read port; unknown address returns status, status write is a read
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            acc_rdata_o <= 8'h00;
            acc_ack_o <= 1'b0;
        end else if (acc_valid_i) begin
            acc_ack_o <= addr_known(acc_addr_i);
            if (!addr_known(acc_addr_i) || acc_addr_i == mlr_pkg::ADDR_STATUS) begin
                acc_rdata_o <= status_flags;
            end else if (acc_addr_i == mlr_pkg::ADDR_CONTROL) begin
                acc_rdata_o <= control_reg;
            end else if (acc_addr_i == mlr_pkg::ADDR_OUTCTL) begin
                acc_rdata_o <= {uout_s, outctl_reg[2:1], outctl_reg[0] & !int_loop};
            end else if (acc_addr_i == mlr_pkg::ADDR_GPIO) begin
                acc_rdata_o <= gpio_s;
            end else begin
                acc_rdata_o <= dir_reg;
            end
        end
    end

    // Transmit disable and line drives
    assign tx_off_now = tx_off_reg || tx_error_off_i || (!carrier_s && !ext_loop) || int_loop;
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tx_disable_n_o <= 1'b0;
            line_drive_a_o <= 1'b1;
            line_drive_b_o <= 1'b1;
        end else begin
            tx_disable_n_o <= !tx_off_now;
            line_drive_a_o <= tx_off_now;
            line_drive_b_o <= tx_off_now;
        end
    end

    // Pin drivers from registers
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            user_output_o <= mlr_pkg::OUTCTL_RESET[7:3];
            gpio_pin_o <= mlr_pkg::GPIO_RESET;
            gpio_pin_oe_o <= mlr_pkg::DIR_RESET;
            int_loop_active_o <= 1'b1;
            ext_loop_active_o <= 1'b0;
        end else begin
            user_output_o <= outctl_reg[7:mlr_pkg::USER_OUT_LSB];
            gpio_pin_o <= gpio_reg;
            gpio_pin_oe_o <= dir_reg;
            int_loop_active_o <= int_loop;
            ext_loop_active_o <= ext_loop;
        end
    end

    // Codec feature controls
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            scrambler_off_o <= 1'b0;
            descrambler_off_o <= 1'b0;
            silence_adder_off_o <= 1'b1;
            silence_subtracter_off_o <= 1'b0;
            error_corrector_off_o <= 1'b0;
            duobinary_off_o <= 1'b1;
            bad_input_detect_off_o <= 1'b0;
            sync_disable_o <= 1'b0;
            no_transition_off_o <= 1'b1;
            sync_clock_sel_o <= 1'b1;
        end else begin
            scrambler_off_o <= control_reg[mlr_pkg::SCRAMBLER_OFF_BIT];
            descrambler_off_o <= control_reg[mlr_pkg::DESCRAMBLER_OFF_BIT];
            silence_adder_off_o <= control_reg[mlr_pkg::ADDER_OFF_BIT] || (loop_mode == mlr_pkg::MLR_LOOP_NONE) ||
                                   (int_loop && !mreq_n_s);
            silence_subtracter_off_o <= control_reg[mlr_pkg::SUBTRACTER_OFF_BIT];
            error_corrector_off_o <= control_reg[mlr_pkg::CORRECTOR_OFF_BIT];
            duobinary_off_o <= outctl_reg[mlr_pkg::DUOBINARY_OFF_BIT] || int_loop;
            bad_input_detect_off_o <= outctl_reg[mlr_pkg::BAD_INPUT_OFF_BIT];
            sync_disable_o <= outctl_reg[mlr_pkg::SYNC_OFF_BIT] && !int_loop;
            no_transition_off_o <= int_loop;
            sync_clock_sel_o <= int_loop;
        end
    end

    // Carrier gating of delimiter and gain hold
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            start_delim_found_o <= 1'b0;
            gain_hold_n_o <= 1'b0;
        end else begin
            start_delim_found_o <= raw_delim_found_i && (carrier_s || int_loop);
            gain_hold_n_o <= carrier_s;
        end
    end

    // Clock choice itself is steered downstream from sync_clock_sel_o
    logic unused_clk;
    assign unused_clk = line_symbol_clock_i ^ rx_clock_i;
endmodule : mlr_regs
`default_nettype wire

/* File: tb/mlr_regs_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module mlr_regs_chk (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    // Commands and access
    input wire logic reset_cmd_i,
    input wire logic loop_disable_cmd_i,
    input wire logic acc_valid_i,
    input wire logic acc_write_i,
    input wire logic [5:0] acc_addr_i,
    input wire logic [7:0] acc_wdata_i,
    input wire logic acc_ack_o,
    // Pins and loop state
    input wire logic carrier_detect_i,
    input wire logic int_loop_active_o,
    input wire logic ext_loop_active_o,
    input wire logic tx_disable_n_o,
    input wire logic line_drive_a_o,
    input wire logic line_drive_b_o,
    input wire logic [4:0] user_output_o,
    input wire logic duobinary_off_o,
    input wire logic sync_clock_sel_o,
    input wire logic no_transition_off_o,
    input wire logic gain_hold_n_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);
    logic known_addr;
    logic [4:0] wr_user;
    logic outctl_wr;
    assign outctl_wr = !reset_cmd_i && acc_valid_i && acc_write_i && acc_addr_i == mlr_pkg::ADDR_OUTCTL;
    assign known_addr = acc_addr_i inside {mlr_pkg::ADDR_STATUS, mlr_pkg::ADDR_CONTROL, mlr_pkg::ADDR_OUTCTL,
                                           mlr_pkg::ADDR_GPIO, mlr_pkg::ADDR_DIR};
    assign wr_user = acc_wdata_i[7:3];
    AST_INT_TX_OFF: assert property (int_loop_active_o |-> !tx_disable_n_o && line_drive_a_o && line_drive_b_o)
        else $error("line drives not forced in internal loop");
    AST_ONE_LOOP: assert property (!(int_loop_active_o && ext_loop_active_o))
        else $error("both loop modes active");
    AST_INT_DUO: assert property (int_loop_active_o |-> duobinary_off_o)
        else $error("precoder on in internal loop");
    AST_INT_CLK: assert property (int_loop_active_o |-> sync_clock_sel_o)
        else $error("receive clock not selected in internal loop");
    AST_INT_NTD: assert property (int_loop_active_o |-> no_transition_off_o)
        else $error("no-transition detector on in internal loop");
    AST_GAIN: assert property ((!carrier_detect_i) [*4] |-> !gain_hold_n_o)
        else $error("gain hold not low without carrier");
    AST_ACK: assert property (acc_valid_i && known_addr |=> acc_ack_o)
        else $error("valid address not acknowledged");
    AST_NACK: assert property (acc_valid_i && !known_addr |=> !acc_ack_o)
        else $error("unknown address acknowledged");
    AST_USER_OUT: assert property (outctl_wr |-> ##2 user_output_o == $past(wr_user, 2))
        else $error("user outputs do not follow write");
    AST_LOOP_OFF: assert property ($rose(loop_disable_cmd_i) |-> ##[1:3] !int_loop_active_o && !ext_loop_active_o)
        else $error("loop still active after disable");
    AST_RST_CMD: assert property ($rose(reset_cmd_i) |-> ##[1:3] int_loop_active_o && !tx_disable_n_o)
        else $error("reset command did not restore internal loop");
endmodule : mlr_regs_chk
bind mlr_regs mlr_regs_chk u_chk (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .reset_cmd_i(reset_cmd_i),
    .loop_disable_cmd_i(loop_disable_cmd_i), .acc_valid_i(acc_valid_i), .acc_write_i(acc_write_i),
    .acc_addr_i(acc_addr_i), .acc_wdata_i(acc_wdata_i), .acc_ack_o(acc_ack_o), .carrier_detect_i(carrier_detect_i),
    .int_loop_active_o(int_loop_active_o), .ext_loop_active_o(ext_loop_active_o), .tx_disable_n_o(tx_disable_n_o),
    .line_drive_a_o(line_drive_a_o), .line_drive_b_o(line_drive_b_o), .user_output_o(user_output_o),
    .duobinary_off_o(duobinary_off_o), .sync_clock_sel_o(sync_clock_sel_o),
    .no_transition_off_o(no_transition_off_o), .gain_hold_n_o(gain_hold_n_o));
`default_nettype wire

/* File: tb/mlr_mgmt_model.sv */
`timescale 1ns/1ps
`default_nettype none
module mlr_mgmt_model (
    // Clock
    input wire logic core_clk_i,
    // Requests
    output logic acc_valid_o,
    output logic acc_write_o,
    output logic [5:0] acc_addr_o,
    output logic [7:0] acc_wdata_o,
    output logic [2:0] cmd_o,
    // Answer
    input wire logic [7:0] acc_rdata_i,
    input wire logic acc_ack_i
);
    initial begin
        acc_valid_o = 1'b0;
        acc_write_o = 1'b0;
        acc_addr_o = 6'h00;
        acc_wdata_o = 8'h00;
        cmd_o = 3'h0;
    end
    // One access; answer stands until the next one
    task automatic access(input logic wr, input logic [5:0] a, input logic [7:0] d, output logic [7:0] q,
                          output logic k);
        @(negedge core_clk_i);
        acc_valid_o = 1'b1;
        acc_write_o = wr;
        acc_addr_o = a;
        acc_wdata_o = d;
        @(negedge core_clk_i);
        acc_valid_o = 1'b0;
        acc_wdata_o = ~d;
        @(negedge core_clk_i);
        q = acc_rdata_i;
        k = acc_ack_i;
    endtask : access
    // Pulse: bit 0 reset, bit 1 loop disable, bit 2 transmitter enable
    task automatic command(input logic [2:0] c);
        @(negedge core_clk_i);
        cmd_o = c;
        @(negedge core_clk_i);
        cmd_o = 3'h0;
        repeat (4) @(negedge core_clk_i);
    endtask : command
endmodule : mlr_mgmt_model
`default_nettype wire

/* File: tb/test_modem_loopback_and_mode_registers.sv */
`timescale 1ns/1ps
`default_nettype none
module test_modem_loopback_and_mode_registers;
    logic core_clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic jabber_n = 1'b1, fault_n = 1'b1, carrier = 1'b1, mgmt_n = 1'b1, raw_delim = 1'b0, bad_in = 1'b0;
    logic tx_err = 1'b0;
    logic acc_v, acc_w, ack, ack_seen, int_l, ext_l, txd_n, drv_a, drv_b;
    logic scr_off, dscr_off, add_off, sub_off, ecc_off, duo_off, bid_off, sync_disable, clk_sel, ntd_off, sdf, gh_n;
    logic [2:0] cmd;
    logic [5:0] acc_a;
    logic [7:0] acc_d, rdata, q, q0, gpio_o, gpio_oe, gpio_in;
    logic [7:0] gpio_ext = 8'h00;
    logic [4:0] user_o, lvl_mask = 5'h00;
    int failures = 0;
    int n_checks = 0;
    // Pin levels seen back by the block
    assign gpio_in = (gpio_oe & gpio_o) | (~gpio_oe & gpio_ext);
    mlr_mgmt_model u_mgmt (.core_clk_i(core_clk_i), .acc_valid_o(acc_v), .acc_write_o(acc_w), .acc_addr_o(acc_a),
        .acc_wdata_o(acc_d), .cmd_o(cmd), .acc_rdata_i(rdata), .acc_ack_i(ack));
    mlr_regs DUT (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .reset_cmd_i(cmd[0]), .loop_disable_cmd_i(cmd[1]),
        .tx_enable_cmd_i(cmd[2]), .acc_valid_i(acc_v), .acc_write_i(acc_w), .acc_addr_i(acc_a), .acc_wdata_i(acc_d),
        .acc_rdata_o(rdata), .acc_ack_o(ack), .jabber_n_i(jabber_n), .fault_n_i(fault_n), .carrier_detect_i(carrier),
        .mgmt_request_n_i(mgmt_n), .user_out_level_i(user_o ^ lvl_mask), .gpio_pin_i(gpio_in), .bad_input_i(bad_in),
        .tx_error_off_i(tx_err), .line_symbol_clock_i(1'b0), .rx_clock_i(1'b0), .raw_delim_found_i(raw_delim),
        .int_loop_active_o(int_l), .ext_loop_active_o(ext_l), .tx_disable_n_o(txd_n), .line_drive_a_o(drv_a),
        .line_drive_b_o(drv_b), .user_output_o(user_o), .gpio_pin_o(gpio_o), .gpio_pin_oe_o(gpio_oe),
        .scrambler_off_o(scr_off), .descrambler_off_o(dscr_off), .silence_adder_off_o(add_off),
        .silence_subtracter_off_o(sub_off), .error_corrector_off_o(ecc_off), .duobinary_off_o(duo_off),
        .bad_input_detect_off_o(bid_off), .sync_disable_o(sync_disable), .sync_clock_sel_o(clk_sel),
        .no_transition_off_o(ntd_off), .start_delim_found_o(sdf), .gain_hold_n_o(gh_n));
    initial begin
        forever #5 core_clk_i = ~core_clk_i;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        u_mgmt.access(1'b1, a, d, q, ack_seen);
    endtask : wr
    task automatic rd(input logic [5:0] a);
        u_mgmt.access(1'b0, a, 8'h00, q, ack_seen);
    endtask : rd
    task automatic idle();
        repeat (6) @(negedge core_clk_i);
    endtask : idle
    task automatic t_reset();
        logic [5:0] adr [5] = '{mlr_pkg::ADDR_STATUS, mlr_pkg::ADDR_CONTROL, mlr_pkg::ADDR_OUTCTL,
                                mlr_pkg::ADDR_GPIO, mlr_pkg::ADDR_DIR};
        logic [7:0] val [5] = '{8'hb0, 8'h22, 8'hc0, 8'h00, 8'h00};
        for (int i = 0; i < 5; i++) begin
            rd(adr[i]);
            check(q, val[i]);
            check(ack_seen, 1'b1);
        end
        check({int_l, ext_l, txd_n, drv_a, drv_b}, 5'b10011);
        check(user_o, 5'h18);
        check(gpio_oe, 8'h00);
        $display("test reset values done");
    endtask : t_reset
    task automatic t_modes();
        logic [7:0] ctl [4] = '{8'h02, 8'h04, 8'h00, 8'h06};
        logic [2:0] top [4] = '{3'b101, 3'b110, 3'b100, 3'b100};
        wr(mlr_pkg::ADDR_CONTROL, 8'hfb);
        rd(mlr_pkg::ADDR_CONTROL);
        check(q, 8'hfa);
        check({scr_off, dscr_off, add_off, sub_off, ecc_off}, 5'h1f);
        for (int i = 0; i < 4; i++) begin
            wr(mlr_pkg::ADDR_CONTROL, ctl[i]);
            rd(mlr_pkg::ADDR_STATUS);
            check(q[7:5], top[i]);
            check({ext_l, int_l}, top[i][1:0]);
        end
        wr(mlr_pkg::ADDR_CONTROL, 8'h02);
        mgmt_n = 1'b0;
        carrier = 1'b0;
        raw_delim = 1'b1;
        idle();
        check({add_off, clk_sel, ntd_off, sdf, gh_n}, 5'b11110);
        mgmt_n = 1'b1;
        idle();
        check(add_off, 1'b0);
        wr(mlr_pkg::ADDR_CONTROL, 8'h04);
        u_mgmt.command(3'b100);
        rd(mlr_pkg::ADDR_STATUS);
        check(q[4:3], 2'b01);
        check({txd_n, ext_l}, 2'b11);
        check({drv_a, drv_b}, 2'b00);
        tx_err = 1'b1;
        idle();
        check({txd_n, drv_a, drv_b}, 3'b011);
        tx_err = 1'b0;
        carrier = 1'b1;
        raw_delim = 1'b0;
        idle();
        $display("test loop modes done");
    endtask : t_modes
    task automatic t_outctl();
        wr(mlr_pkg::ADDR_CONTROL, 8'h02);
        wr(mlr_pkg::ADDR_OUTCTL, 8'h01);
        idle();
        rd(mlr_pkg::ADDR_OUTCTL);
        check(q, 8'h00);
        check(duo_off, 1'b1);
        wr(mlr_pkg::ADDR_CONTROL, 8'h00);
        rd(mlr_pkg::ADDR_OUTCTL);
        check(q, 8'h01);
        lvl_mask = 5'h01;
        wr(mlr_pkg::ADDR_OUTCTL, 8'hae);
        idle();
        rd(mlr_pkg::ADDR_OUTCTL);
        check(q, 8'ha6);
        check(user_o, 5'h15);
        check({sync_disable, bid_off, duo_off}, 3'b110);
        lvl_mask = 5'h00;
        $display("test output control done");
    endtask : t_outctl
    task automatic t_gpio();
        gpio_ext = 8'h5a;
        wr(mlr_pkg::ADDR_GPIO, 8'hc3);
        idle();
        rd(mlr_pkg::ADDR_GPIO);
        check(q, 8'h5a);
        wr(mlr_pkg::ADDR_DIR, 8'h0f);
        idle();
        check(gpio_oe, 8'h0f);
        check(gpio_o & gpio_oe, 8'h03);
        rd(mlr_pkg::ADDR_GPIO);
        check(q, 8'h53);
        rd(mlr_pkg::ADDR_STATUS);
        q0 = q;
        wr(mlr_pkg::ADDR_STATUS, ~q0);
        rd(mlr_pkg::ADDR_STATUS);
        check(q, q0);
        rd(6'h10);
        check(q, q0);
        check(ack_seen, 1'b0);
        $display("test general io done");
    endtask : t_gpio
    task automatic t_commands();
        u_mgmt.command(3'b010);
        rd(mlr_pkg::ADDR_STATUS);
        check(q[7:5], 3'b000);
        check(int_l, 1'b0);
        jabber_n = 1'b0;
        fault_n = 1'b0;
        bad_in = 1'b1;
        idle();
        jabber_n = 1'b1;
        fault_n = 1'b1;
        bad_in = 1'b0;
        idle();
        u_mgmt.command(3'b001);
        rd(mlr_pkg::ADDR_STATUS);
        check(q, 8'hb3);
        rd(mlr_pkg::ADDR_CONTROL);
        check(q, 8'h22);
        rd(mlr_pkg::ADDR_DIR);
        check(q, 8'h00);
        check(gpio_oe, 8'h00);
        bad_in = 1'b1;
        idle();
        bad_in = 1'b0;
        u_mgmt.command(3'b001);
        rd(mlr_pkg::ADDR_STATUS);
        check(q, 8'hb4);
        $display("test commands done");
    endtask : t_commands
    task automatic final_report();
        $display("checks=%0d failures=%0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : final_report
    initial begin
        repeat (3) @(negedge core_clk_i);
        reset_n_i = 1'b1;
        idle();
        t_reset();
        t_modes();
        t_outctl();
        t_gpio();
        t_commands();
        final_report();
    end
    initial begin
        #100000;
        failures++;
        final_report();
    end
endmodule : test_modem_loopback_and_mode_registers
`default_nettype wire
